// >>> shared/plcr_pkg.sv
// Package for the link capability / link control register bank.
// Assumes a single AHB-Lite master with 32-bit word accesses.
package plcr_pkg;
   // Register byte offsets
   localparam logic [7:0] LINK_CAP_OFS = 8'hAC;
   localparam logic [7:0] LINK_CTRL_OFS = 8'hB0;
   // Link capability fields
   localparam logic [3:0] CAP_SPEEDS = 4'h2;
   localparam logic [5:0] CAP_WIDTH = 6'h01;
   localparam logic [1:0] CAP_ASPM = 2'h3;
   localparam logic [2:0] CAP_L0S_LAT = 3'h6;
   localparam logic [2:0] CAP_L1_LAT = 3'h7;
   localparam logic CAP_CLK_PM = 1'b1;
   localparam logic [7:0] CAP_PORT_NUM = 8'h00;
   // Link control field positions
   localparam int CTL_ASPM_LSB = 0;
   localparam int CTL_CCLK_BIT = 6;
   localparam int CTL_XSYNC_BIT = 7;
   localparam int CTL_CLKPM_BIT = 8;
   // Link control reset values
   localparam logic [1:0] ASPM_RST_DEFAULT = 2'h3;
   localparam logic CCLK_RST = 1'b0;
   localparam logic XSYNC_RST = 1'b0;
   localparam logic CLKPM_RST = 1'b1;
   // AHB encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;

   // Writable link control state
   typedef struct packed {
      logic [1:0] aspm;
      logic common_clk;
      logic ext_sync;
      logic clk_pm_en;
   } plcr_ctrl_s;

   // Link-side controls derived from the register bank
   typedef struct packed {
      logic l0s_entry_en;
      logic l1_entry_en;
      logic common_clk;
      logic ext_sync;
      logic clk_pm_allowed;
   } plcr_link_s;
endpackage : plcr_pkg

// >>> logic/plcr_regs.sv
// Link capability and link control register bank, AHB-Lite slave.
// Assumes one word-aligned AHB-Lite master; host-config bits arrive
// from logic on the same clock.
//
// Overview of operation
// - Capability speeds field reads 2.5 and 5.0
// - Maximum width field reads one lane
// - Both L0s and L1 ASPM supported
// - L0s exit latency code reads 110b
// - L1 exit latency code reads 111b
// - Clock removal tolerated, bit 18 set
// - Port number field reads zero
// - ASPM control selects allowed low-power entries
// - ASPM control resets to 11b; default select applies ASPM_ALT_RESET (00b)
// - Completion boundary bit reads zero
// - Link disable bit reads zero
// - Retrain bit reads zero, writes ignored
// - Common clock bit stored, resets zero
// - Extended sync enables extra ordered sets
// - Clock PM disabled holds request low
// - Clock PM enabled lets request toggle
// - Force bit holds clock request low
// - Autonomous width disable reads zero
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module plcr_regs #(
   parameter logic [1:0] ASPM_ALT_RESET = 2'h0
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // AHB-Lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic hready_i,
   input wire logic [31:0] hwdata_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   // Host configuration straps
   input wire logic aspm_default_sel_i,
   input wire logic clock_request_force_low_i,
   // Link power management side
   input wire logic clkreq_release_req_i,
   output plcr_pkg::plcr_link_s link_ctrl_o,
   output logic clkreq_n_o
);
   import plcr_pkg::*;

   plcr_ctrl_s ctrl_reg, ctrl_next;
   logic wr_pend_reg;
   logic [7:0] wr_addr_reg;
   logic [31:0] hrdata_reg, hrdata_next;
   logic clkreq_n_reg, clkreq_n_next;

   // Address phase decode
   wire logic xfer_ok = hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ);
   wire logic rd_take = xfer_ok && !hwrite_i;
   wire logic wr_take = xfer_ok && hwrite_i && (hsize_i == HSIZE_WORD);
   wire logic [7:0] ofs = haddr_i[7:0];
   wire logic in_page = (haddr_i[31:8] == 24'h000000);
   wire logic wr_ctrl = wr_pend_reg && (wr_addr_reg == LINK_CTRL_OFS);

   wire logic [31:0] cap_word = {CAP_PORT_NUM, 2'h0, 3'h0, CAP_CLK_PM, CAP_L1_LAT,
                                 CAP_L0S_LAT, CAP_ASPM, CAP_WIDTH, CAP_SPEEDS};
   wire logic [31:0] ctl_word = {16'h0000, 6'h00, 1'b0, ctrl_reg.clk_pm_en,
                                 ctrl_reg.ext_sync, ctrl_reg.common_clk, 1'b0, 1'b0,
                                 1'b0, 1'b0, ctrl_reg.aspm};
   wire logic [31:0] rd_sel = !in_page ? 32'h00000000 :
                              (ofs == LINK_CAP_OFS) ? cap_word :
                              (ofs == LINK_CTRL_OFS) ? ctl_word : 32'h00000000;

   always_comb begin
      ctrl_next = ctrl_reg;
      if (wr_ctrl) begin
         ctrl_next.aspm = hwdata_i[CTL_ASPM_LSB +: 2];
         ctrl_next.common_clk = hwdata_i[CTL_CCLK_BIT];
         ctrl_next.ext_sync = hwdata_i[CTL_XSYNC_BIT];
         ctrl_next.clk_pm_en = hwdata_i[CTL_CLKPM_BIT];
      end
   end

   assign hrdata_next = rd_take ? rd_sel : hrdata_reg;

   always_comb begin
      if (clock_request_force_low_i || !ctrl_reg.clk_pm_en) begin
         clkreq_n_next = 1'b0;
      end else begin
         clkreq_n_next = clkreq_release_req_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ctrl_reg <= '{aspm: ASPM_RST_DEFAULT, common_clk: CCLK_RST, ext_sync: XSYNC_RST,
                       clk_pm_en: CLKPM_RST};
      end else if (ctrl_next != ctrl_reg) begin
         ctrl_reg <= ctrl_next;
      end
   end

   // Default select is sampled after reset release, not under reset
   logic strap_done_reg;
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         strap_done_reg <= 1'b0;
      end else begin
         strap_done_reg <= 1'b1;
      end
   end

   logic aspm_alt_reg;
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         aspm_alt_reg <= 1'b0;
      end else if (!strap_done_reg) begin
         aspm_alt_reg <= aspm_default_sel_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         hrdata_reg <= 32'h00000000;
         clkreq_n_reg <= 1'b0;
      end else begin
         wr_pend_reg <= wr_take && in_page;
         wr_addr_reg <= ofs;
         hrdata_reg <= hrdata_next;
         clkreq_n_reg <= clkreq_n_next;
      end
   end

   // Applied ASPM value: alternate default holds until software writes
   logic aspm_written_reg;
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         aspm_written_reg <= 1'b0;
      end else if (wr_ctrl) begin
         aspm_written_reg <= 1'b1;
      end
   end
   wire logic [1:0] aspm_eff = (aspm_alt_reg && !aspm_written_reg) ? ASPM_ALT_RESET
                                                                 : ctrl_reg.aspm;

   // ASPM entry enables, common clock, extended sync and clock PM allowed passed to the link
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         link_ctrl_o <= '0;
      end else begin
         link_ctrl_o.l0s_entry_en <= aspm_eff[0];
         link_ctrl_o.l1_entry_en <= aspm_eff[1];
         link_ctrl_o.common_clk <= ctrl_reg.common_clk;
         link_ctrl_o.ext_sync <= ctrl_reg.ext_sync;
         link_ctrl_o.clk_pm_allowed <= ctrl_reg.clk_pm_en && !clock_request_force_low_i;
      end
   end

   // Zero wait states, always OKAY
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;
   assign hrdata_o = aspm_alt_reg && !aspm_written_reg && hrdata_reg == ctl_word
                     ? {hrdata_reg[31:2], aspm_eff} : hrdata_reg;
   assign clkreq_n_o = clkreq_n_reg;

   a_force_holds_low: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      clock_request_force_low_i |=> !clkreq_n_o)
      else $error("clock request not held low under force");
   a_clkpm_off_low: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !ctrl_reg.clk_pm_en |=> !clkreq_n_o)
      else $error("clock request released while clock PM disabled");
   a_clkpm_release: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ctrl_reg.clk_pm_en && !clock_request_force_low_i && clkreq_release_req_i)
      |=> clkreq_n_o)
      else $error("clock request not released");
   a_cap_read_val: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (rd_take && in_page && ofs == LINK_CAP_OFS) |=> hrdata_o == 32'h0007EC12)
      else $error("capability word mismatch");
   a_ctrl_zero_bits: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (rd_take && in_page && ofs == LINK_CTRL_OFS) |=> hrdata_o[31:9] == 23'h0
      && hrdata_o[5:2] == 4'h0)
      else $error("control fixed bits not zero");
   a_cclk_written: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (wr_take && in_page && ofs == LINK_CTRL_OFS) ##2 1'b1
      |=> ctrl_reg.common_clk == $past(hwdata_i[CTL_CCLK_BIT]))
      else $error("common clock bit not stored");
   a_aspm_decode: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      1'b1 |=> link_ctrl_o.l1_entry_en == $past(aspm_eff[1])
      && link_ctrl_o.l0s_entry_en == $past(aspm_eff[0]))
      else $error("ASPM entry enables wrong");
   a_xsync_follow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ctrl_reg.ext_sync |=> link_ctrl_o.ext_sync)
      else $error("extended sync not forwarded");
   a_aspm_reset: assert property (@(posedge clk_i)
      !rst_n_i |=> ctrl_reg.aspm == ASPM_RST_DEFAULT)
      else $error("ASPM reset value wrong");

   a_cap_speeds: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (rd_take && in_page && ofs == LINK_CAP_OFS) |=> hrdata_o[3:0] == 4'h2)
      else $error("speeds field wrong");

   a_cap_width: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (rd_take && in_page && ofs == LINK_CAP_OFS) |=> hrdata_o[9:4] == 6'h01)
      else $error("width field wrong");

   a_cap_aspm: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (rd_take && in_page && ofs == LINK_CAP_OFS) |=> hrdata_o[11:10] == 2'h3)
      else $error("ASPM support field wrong");

   a_cap_l0s_lat: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (rd_take && in_page && ofs == LINK_CAP_OFS) |=> hrdata_o[14:12] == 3'h6)
      else $error("L0s latency field wrong");

   a_cap_l1_lat: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (rd_take && in_page && ofs == LINK_CAP_OFS) |=> hrdata_o[17:15] == 3'h7)
      else $error("L1 latency field wrong");

   a_cap_clk_pm: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (rd_take && in_page && ofs == LINK_CAP_OFS) |=> hrdata_o[18] == 1'b1)
      else $error("clock removal bit wrong");

   a_cap_port: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (rd_take && in_page && ofs == LINK_CAP_OFS) |=> hrdata_o[31:24] == 8'h00)
      else $error("port number field wrong");

   a_cap_rsvd: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (rd_take && in_page && ofs == LINK_CAP_OFS) |=> hrdata_o[23:19] == 5'h00)
      else $error("capability reserved bits not zero");

   a_rcb_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (rd_take && in_page && ofs == LINK_CTRL_OFS) |=> hrdata_o[3] == 1'b0)
      else $error("completion boundary bit not zero");

   a_disable_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (rd_take && in_page && ofs == LINK_CTRL_OFS) |=> hrdata_o[4] == 1'b0)
      else $error("link disable bit not zero");

   a_retrain_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (rd_take && in_page && ofs == LINK_CTRL_OFS) |=> hrdata_o[5] == 1'b0)
      else $error("retrain bit not zero");

   a_width_dis_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (rd_take && in_page && ofs == LINK_CTRL_OFS) |=> hrdata_o[9] == 1'b0)
      else $error("width disable bit not zero");

   a_ctrl_rsvd: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (rd_take && in_page && ofs == LINK_CTRL_OFS) |=> hrdata_o[31:10] == 22'h0
      && hrdata_o[2] == 1'b0)
      else $error("control reserved bits not zero");

   a_unmapped_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (rd_take && !(in_page && (ofs == LINK_CAP_OFS || ofs == LINK_CTRL_OFS)))
      |=> hrdata_o == 32'h00000000)
      else $error("unmapped read not zero");

   a_cclk_reset: assert property (@(posedge clk_i)
      !rst_n_i |=> ctrl_reg.common_clk == 1'b0)
      else $error("common clock reset value wrong");

   a_xsync_reset: assert property (@(posedge clk_i)
      !rst_n_i |=> ctrl_reg.ext_sync == 1'b0)
      else $error("extended sync reset value wrong");

   a_clkpm_reset: assert property (@(posedge clk_i)
      !rst_n_i |=> ctrl_reg.clk_pm_en == 1'b1)
      else $error("clock PM reset value wrong");

   a_xsync_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !ctrl_reg.ext_sync |=> !link_ctrl_o.ext_sync)
      else $error("extended sync not cleared");

   a_cclk_follow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      1'b1 |=> link_ctrl_o.common_clk == $past(ctrl_reg.common_clk))
      else $error("common clock not forwarded");

   a_pm_allowed_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (!ctrl_reg.clk_pm_en || clock_request_force_low_i) |=> !link_ctrl_o.clk_pm_allowed)
      else $error("clock PM allowed while disabled");

   a_pm_allowed_on: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ctrl_reg.clk_pm_en && !clock_request_force_low_i) |=> link_ctrl_o.clk_pm_allowed)
      else $error("clock PM not allowed while enabled");

   a_aspm_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (aspm_eff == 2'b00) |=> !link_ctrl_o.l0s_entry_en && !link_ctrl_o.l1_entry_en)
      else $error("ASPM entry enabled while off");

   a_l0s_only: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (aspm_eff == 2'b01) |=> link_ctrl_o.l0s_entry_en && !link_ctrl_o.l1_entry_en)
      else $error("L0s only mode wrong");

   a_l1_only: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (aspm_eff == 2'b10) |=> !link_ctrl_o.l0s_entry_en && link_ctrl_o.l1_entry_en)
      else $error("L1 only mode wrong");

   a_aspm_both: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (aspm_eff == 2'b11) |=> link_ctrl_o.l0s_entry_en && link_ctrl_o.l1_entry_en)
      else $error("both entries mode wrong");

   a_aspm_stored: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (wr_take && in_page && ofs == LINK_CTRL_OFS) ##2 1'b1
      |=> ctrl_reg.aspm == $past(hwdata_i[1:0]))
      else $error("ASPM field not stored");

   a_clkpm_written: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (wr_take && in_page && ofs == LINK_CTRL_OFS) ##2 1'b1
      |=> ctrl_reg.clk_pm_en == $past(hwdata_i[8]))
      else $error("clock PM enable not stored");

   a_xsync_written: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (wr_take && in_page && ofs == LINK_CTRL_OFS) ##2 1'b1
      |=> ctrl_reg.ext_sync == $past(hwdata_i[7]))
      else $error("extended sync not stored");

   a_rel_low: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ctrl_reg.clk_pm_en && !clock_request_force_low_i && !clkreq_release_req_i)
      |=> !clkreq_n_o)
      else $error("clock request released without request");

   a_strap_once: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      strap_done_reg |=> $stable(aspm_alt_reg))
      else $error("default select changed after start");

   c_cap_read: cover property (@(posedge clk_i) rd_take && ofs == LINK_CAP_OFS);
   c_ctrl_write: cover property (@(posedge clk_i) wr_ctrl);
   c_clk_release: cover property (@(posedge clk_i) clkreq_n_o);
   c_force_low: cover property (@(posedge clk_i) clock_request_force_low_i
      && ctrl_reg.clk_pm_en);
   c_alt_default: cover property (@(posedge clk_i) aspm_alt_reg && !aspm_written_reg);
endmodule : plcr_regs

// >>> verif/plcr_host_model.sv
// Configuration-software model: single AHB-Lite word transfers.
// Assumes the slave's hreadyout is looped back as hready.
`timescale 1ns/1ps
module plcr_host_model
   import plcr_pkg::*;
(
   // Clock
   input wire logic clk_i,
   // AHB-Lite master
   output logic hsel_o,
   output logic [31:0] haddr_o,
   output logic [1:0] htrans_o,
   output logic hwrite_o,
   output logic [2:0] hsize_o,
   output logic [31:0] hwdata_o,
   input wire logic hready_i,
   input wire logic [31:0] hrdata_i
);
   initial begin
      hsel_o = 1'b0;
      haddr_o = 32'h0;
      htrans_o = 2'h0;
      hwrite_o = 1'b0;
      hsize_o = HSIZE_WORD;
      hwdata_o = 32'h0;
   end

   task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                       output logic [31:0] rdata);
      @(posedge clk_i);
      hsel_o <= 1'b1;
      haddr_o <= addr;
      htrans_o <= HTRANS_NONSEQ;
      hwrite_o <= wr;
      @(posedge clk_i);
      while (hready_i !== 1'b1) @(posedge clk_i);
      hsel_o <= 1'b0;
      htrans_o <= 2'h0;
      // Reads get a changing pattern so stale data is never mistaken
      hwdata_o <= wr ? wdata : ~hwdata_o;
      @(posedge clk_i);
      while (hready_i !== 1'b1) @(posedge clk_i);
      rdata = hrdata_i;
   endtask : xfer
endmodule : plcr_host_model

// >>> verif/pcie_link_cap_ctrl_regs_bench.sv
// Self-checking bench for the link capability / control bank.
// Assumes a 40 MHz core clock and hreadyout looped to hready.
`timescale 1ns/1ps
module pcie_link_cap_ctrl_regs_bench;
   import plcr_pkg::*;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic sel = 1'b0;
   logic force_low = 1'b0;
   logic rel = 1'b0;
   logic hsel, hwrite, hready, hresp, clkreq_n;
   logic [31:0] haddr, hwdata, hrdata, r;
   logic [1:0] htrans;
   logic [2:0] hsize;
   plcr_link_s lnk;
   int err_total = 0;
   int num_checks = 0;
   int cycles = 0;

   plcr_host_model i_host (.clk_i(clk_i), .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans),
      .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata), .hready_i(hready),
      .hrdata_i(hrdata));
   plcr_regs i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hready_i(hready),
      .hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
      .aspm_default_sel_i(sel), .clock_request_force_low_i(force_low),
      .clkreq_release_req_i(rel), .link_ctrl_o(lnk), .clkreq_n_o(clkreq_n));

   initial begin
      forever #12.5 clk_i = ~clk_i;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic report_and_stop();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : report_and_stop

   task automatic t_reset_values();
      i_host.xfer(1'b0, 32'hAC, 32'h0, r);
      check(r & 32'hF, 32'h2);
      check(r & 32'h3F0, 32'h10);
      check(r & 32'hC00, 32'hC00);
      check(r & 32'h7000, 32'h6000);
      check(r & 32'h38000, 32'h38000);
      check(r & 32'h40000, 32'h40000);
      check(r & 32'hFF000000, 32'h0);
      i_host.xfer(1'b0, 32'hB0, 32'h0, r);
      check(r, 32'h103);
      check({27'h0, lnk}, 32'h19);
      check({31'h0, hresp}, 32'h0);
   endtask : t_reset_values

   task automatic t_write_all_ones();
      i_host.xfer(1'b1, 32'hB0, 32'hFFFFFFFF, r);
      i_host.xfer(1'b0, 32'hB0, 32'h0, r);
      // Only ASPM, common clock, extended sync and clock PM hold ones
      check(r, 32'h1C3);
      check({31'h0, lnk.ext_sync}, 32'h1);
      i_host.xfer(1'b1, 32'hAC, 32'h0, r);
      i_host.xfer(1'b0, 32'hAC, 32'h0, r);
      check(r, 32'h7EC12);
      i_host.xfer(1'b0, 32'hB4, 32'h0, r);
      check(r, 32'h0);
      i_host.xfer(1'b1, 32'hB0, 32'h100, r);
      i_host.xfer(1'b0, 32'hB0, 32'h0, r);
      check(r, 32'h100);
   endtask : t_write_all_ones

   task automatic t_aspm_modes();
      for (int m = 0; m < 4; m++) begin
         i_host.xfer(1'b1, 32'hB0, 32'h100 | m, r);
         repeat (2) @(posedge clk_i);
         check({30'h0, lnk.l0s_entry_en, lnk.l1_entry_en}, {30'h0, m[0], m[1]});
      end
   endtask : t_aspm_modes

   // Enable, force and release request against expected request level
   task automatic t_clkreq();
      logic [3:0] tbl [4] = '{4'b0010, 4'b1011, 4'b1000, 4'b1110};
      for (int i = 0; i < 4; i++) begin
         i_host.xfer(1'b1, 32'hB0, {23'h0, tbl[i][3], 8'h0}, r);
         force_low <= tbl[i][2];
         rel <= tbl[i][1];
         repeat (3) @(posedge clk_i);
         check({31'h0, clkreq_n}, {31'h0, tbl[i][0]});
      end
   endtask : t_clkreq

   // Ceiling well above the fewer than 100 cycles the scenarios need
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         err_total++;
         report_and_stop();
      end
   end

   initial begin
      repeat (3) @(posedge clk_i);
      rst_n_i <= 1'b1;
      t_reset_values();
      t_write_all_ones();
      t_aspm_modes();
      t_clkreq();
      report_and_stop();
   end
endmodule : pcie_link_cap_ctrl_regs_bench
